// *** common/fpsr_defs.vh ***
`ifndef FPSR_DEFS_VH
`define FPSR_DEFS_VH
// Register offsets (byte addresses)
`define FPSR_REG_CTRL 8'h00
`define FPSR_REG_ADDR 8'h04
`define FPSR_REG_DATA 8'h08
`define FPSR_REG_STAT 8'h0C
`define FPSR_REG_RDAT 8'h10
// Control fields
`define FPSR_CTRL_GO 0
`define FPSR_CTRL_CMD_LSB 1
// Commands
`define FPSR_CMD_PROG 2'h0
`define FPSR_CMD_READ 2'h1
`define FPSR_CMD_RESET 2'h2
// Status fields
`define FPSR_ST_BUSY 0
`define FPSR_ST_DONE 1
`define FPSR_ST_FAIL 2
`define FPSR_ST_RYBY 3
// Flash command codes
`define FPSR_UNLK1_ADDR 20'h00555
`define FPSR_UNLK1_DATA 8'hAA
`define FPSR_UNLK2_ADDR 20'h002AA
`define FPSR_UNLK2_DATA 8'h55
`define FPSR_PROG_CODE 8'hA0
`define FPSR_RESET_CODE 8'hF0
// Status bit positions in the read byte
`define FPSR_BIT_POLL 7
`define FPSR_BIT_TOG1 6
`define FPSR_BIT_TOUT 5
// Bus cycle phase count in clocks (50 ns each); setup and hold last this plus one, the pulse twice this plus one
`define FPSR_PHASE_CYC 4'h3
`endif

// *** rtl/fpsr_bus_cycle.v ***
`timescale 1ns/1ps
// One asynchronous flash bus cycle: write pulse or read with capture
module fpsr_bus_cycle #(
  parameter AW = 20,
  parameter PHASE = 4'h3
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Request
  input wire start,
  input wire is_write,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output wire done,
  output reg [7:0] rdata,
  // Flash pins
  output reg [AW-1:0] flash_addr,
  output reg chip_select_n,
  output reg write_strobe_n,
  output reg output_strobe_n,
  output reg [7:0] dq_out,
  output reg dq_oe_n,
  input wire [7:0] dq_sync
);
  localparam S_IDLE = 2'h0;
  localparam S_SETUP = 2'h1;
  localparam S_PULSE = 2'h2;
  localparam S_HOLD = 2'h3;
  reg [1:0] state;
  reg [3:0] cnt;
  reg wr;
  assign done = (state == S_HOLD) && (cnt == 4'h0);
  // Phases stretched so synchronised read data settles before capture
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= {AW{1'b0}};
      chip_select_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            wr <= is_write;
            flash_addr <= addr;
            dq_out <= wdata;
            dq_oe_n <= ~is_write;
            chip_select_n <= 1'b0;
            cnt <= PHASE;
            state <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt == 4'h0) begin
            write_strobe_n <= ~wr;
            output_strobe_n <= wr;
            cnt <= PHASE + PHASE;
            state <= S_PULSE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        S_PULSE: begin
          if (cnt == 4'h0) begin
            // Each read edge on the output strobe makes the toggle bits move
            if (!wr) begin
              rdata <= dq_sync;
            end
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
            cnt <= PHASE;
            state <= S_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt == 4'h0) begin
            chip_select_n <= 1'b1;
            dq_oe_n <= 1'b1;
            state <= S_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fpsr_bus_cycle

// *** rtl/fpsr_host.v ***
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fpsr_defs.vh"
module fpsr_host #(
  parameter AW = 20
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Flash pins
  output wire [AW-1:0] flash_addr,
  output wire chip_select_n,
  output wire write_strobe_n,
  output wire output_strobe_n,
  output wire [7:0] dq_out,
  output wire dq_oe_n,
  input wire [7:0] dq_in,
  input wire ready_busy_n
);
  localparam F_IDLE = 4'h0;
  localparam F_WR1 = 4'h1;
  localparam F_WR2 = 4'h2;
  localparam F_WR3 = 4'h3;
  localparam F_WR4 = 4'h4;
  localparam F_RDA = 4'h5;
  localparam F_RDB = 4'h6;
  localparam F_JUDGE = 4'h7;
  localparam F_RDC = 4'h8;
  localparam F_RDD = 4'h9;
  localparam F_JUDGE2 = 4'hA;
  localparam F_RESET = 4'hB;
  localparam F_READ = 4'hC;
  localparam F_WAIT = 4'hD;

  reg [3:0] state;
  reg [AW-1:0] addr_reg;
  reg [7:0] data_reg;
  reg [1:0] cmd;
  reg busy;
  reg done_flag;
  reg fail_flag;
  reg [7:0] rd_byte;
  reg [7:0] first_rd;
  reg [7:0] dq_meta;
  reg [7:0] dq_sync;
  reg rb_meta;
  reg rb_sync;
  reg cyc_start;
  reg cyc_write;
  reg [AW-1:0] cyc_addr;
  reg [7:0] cyc_data;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  wire wr_fire;
  wire go_write;
  wire [7:0] toggle_diff;

  // Pins from the flash pass two flops before use
  always @(posedge sys_clk) begin
    if (!rstn) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
      rb_meta <= ready_busy_n;
      rb_sync <= rb_meta;
    end
  end

  fpsr_bus_cycle #(
    .AW(AW),
    .PHASE(`FPSR_PHASE_CYC)
  ) u_cycle (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .dq_sync(dq_sync)
  );

  // AXI write: address and data taken in either order, then response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign go_write = wr_fire && (aw_addr == `FPSR_REG_CTRL) && w_data[`FPSR_CTRL_GO] && !busy;
  always @(posedge sys_clk) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      addr_reg <= {AW{1'b0}};
      data_reg <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr)
          `FPSR_REG_ADDR: addr_reg <= w_data[AW-1:0];
          `FPSR_REG_DATA: data_reg <= w_data[7:0];
          `FPSR_REG_CTRL: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read: one cycle after address acceptance
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `FPSR_REG_CTRL: s_axi_rdata <= {29'h0, cmd, 1'b0};
        `FPSR_REG_ADDR: s_axi_rdata <= {{(32-AW){1'b0}}, addr_reg};
        `FPSR_REG_DATA: s_axi_rdata <= {24'h000000, data_reg};
        `FPSR_REG_STAT: s_axi_rdata <= {28'h0000000, rb_sync, fail_flag, done_flag, busy};
        `FPSR_REG_RDAT: s_axi_rdata <= {24'h000000, rd_byte};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign toggle_diff = first_rd ^ cyc_rdata;

  // Flash sequencer: program command writes then status polling, or one read or reset cycle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state <= F_IDLE;
      cmd <= `FPSR_CMD_PROG;
      busy <= 1'b0;
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      rd_byte <= 8'h00;
      first_rd <= 8'h00;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= {AW{1'b0}};
      cyc_data <= 8'h00;
    end else begin
      cyc_start <= 1'b0;
      case (state)
        F_IDLE: begin
          if (go_write) begin
            cmd <= w_data[`FPSR_CTRL_CMD_LSB+1:`FPSR_CTRL_CMD_LSB];
            busy <= 1'b1;
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
            cyc_start <= 1'b1;
            if (w_data[`FPSR_CTRL_CMD_LSB+1:`FPSR_CTRL_CMD_LSB] == `FPSR_CMD_READ) begin
              cyc_write <= 1'b0;
              cyc_addr <= addr_reg;
              state <= F_READ;
            end else if (w_data[`FPSR_CTRL_CMD_LSB+1:`FPSR_CTRL_CMD_LSB] == `FPSR_CMD_RESET) begin
              cyc_write <= 1'b1;
              cyc_addr <= addr_reg;
              cyc_data <= `FPSR_RESET_CODE;
              state <= F_RESET;
            end else begin
              cyc_write <= 1'b1;
              cyc_addr <= `FPSR_UNLK1_ADDR;
              cyc_data <= `FPSR_UNLK1_DATA;
              state <= F_WR1;
            end
          end
        end
        F_WR1: if (cyc_done) begin
          cyc_start <= 1'b1;
          cyc_addr <= `FPSR_UNLK2_ADDR;
          cyc_data <= `FPSR_UNLK2_DATA;
          state <= F_WR2;
        end
        F_WR2: if (cyc_done) begin
          cyc_start <= 1'b1;
          cyc_addr <= `FPSR_UNLK1_ADDR;
          cyc_data <= `FPSR_PROG_CODE;
          state <= F_WR3;
        end
        F_WR3: if (cyc_done) begin
          // fourth pulse carries target and data
          cyc_start <= 1'b1;
          cyc_addr <= addr_reg;
          cyc_data <= data_reg;
          state <= F_WR4;
        end
        F_WR4: if (cyc_done) begin
          // status read at the programmed address
          cyc_start <= 1'b1;
          cyc_write <= 1'b0;
          state <= F_RDA;
        end
        F_RDA: if (cyc_done) begin
          first_rd <= cyc_rdata;
          cyc_start <= 1'b1;
          state <= F_RDB;
        end
        F_RDB: if (cyc_done) begin
          rd_byte <= cyc_rdata;
          state <= F_JUDGE;
        end
        F_JUDGE: begin
          // toggle stopped means done; poll bit differing from the data also flags failure
          if (!toggle_diff[`FPSR_BIT_TOG1]) begin
            fail_flag <= rd_byte[`FPSR_BIT_POLL] != data_reg[`FPSR_BIT_POLL];
            busy <= 1'b0;
            done_flag <= 1'b1;
            state <= F_IDLE;
          end else if (rd_byte[`FPSR_BIT_TOUT]) begin
            // timeout seen, check toggle once more
            cyc_start <= 1'b1;
            state <= F_RDC;
          end else begin
            // keep polling from the double read
            cyc_start <= 1'b1;
            state <= F_RDA;
          end
        end
        F_RDC: if (cyc_done) begin
          first_rd <= cyc_rdata;
          cyc_start <= 1'b1;
          state <= F_RDD;
        end
        F_RDD: if (cyc_done) begin
          rd_byte <= cyc_rdata;
          state <= F_JUDGE2;
        end
        F_JUDGE2: begin
          if (!toggle_diff[`FPSR_BIT_TOG1]) begin
            busy <= 1'b0;
            done_flag <= 1'b1;
            state <= F_IDLE;
          end else begin
            // still toggling means failure, send reset
            fail_flag <= 1'b1;
            cyc_start <= 1'b1;
            cyc_write <= 1'b1;
            cyc_data <= `FPSR_RESET_CODE;
            state <= F_RESET;
          end
        end
        F_RESET, F_READ: if (cyc_done) begin
          state <= F_WAIT;
        end
        F_WAIT: begin
          if (cmd == `FPSR_CMD_READ) begin
            rd_byte <= cyc_rdata;
          end
          busy <= 1'b0;
          done_flag <= 1'b1;
          state <= F_IDLE;
        end
        default: state <= F_IDLE;
      endcase
    end
  end
endmodule // fpsr_host

// *** tb/fpsr_host_props.sv ***
`timescale 1ns/1ps
`include "fpsr_defs.vh"
module fpsr_host_props #(
  parameter AW = 20
) (
  input wire sys_clk,
  input wire rstn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [AW-1:0] flash_addr,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire [7:0] dq_out,
  input wire dq_oe_n
);
  reg [1:0] step;
  reg pdat;
  reg [2:0] rds;
  reg [AW-1:0] paddr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Unlock step, reads since the last write; saturates so long polls do not wrap
  always @(posedge sys_clk) begin
    if (!rstn) begin
      step <= 2'h0;
      pdat <= 1'b0;
      rds <= 3'h0;
      paddr <= {AW{1'b0}};
    end else if ($fell(write_strobe_n)) begin
      // At step zero, any write whose data is not the first unlock code leaves step at zero
      step <= (step == 2'h0) ? {1'b0, dq_out == `FPSR_UNLK1_DATA} : step + 2'h1;
      pdat <= (step == 2'h3);
      rds <= 3'h0;
      paddr <= (step == 2'h3) ? flash_addr : paddr;
    end else if ($fell(output_strobe_n) && rds != 3'h7) begin
      rds <= rds + 3'h1;
    end
  end
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_UNLOCK2: assert property ($fell(write_strobe_n) && step == 2'h1 |->
    dq_out == `FPSR_UNLK2_DATA && flash_addr == `FPSR_UNLK2_ADDR) else $error("bad unlock");
  AST_PROG_CODE: assert property ($fell(write_strobe_n) && step == 2'h2 |->
    dq_out == `FPSR_PROG_CODE && flash_addr == `FPSR_UNLK1_ADDR) else $error("bad code");
  AST_STATUS_PAIR: assert property ($fell(write_strobe_n) && pdat |-> rds >= 3'h2)
    else $error("write before two status reads");
  AST_RESET_RECHECK: assert property ($fell(write_strobe_n) && dq_out == 8'hF0 && !step[1]
    |-> pdat && rds >= 3'h4) else $error("reset without recheck");
  AST_STATUS_ADDR: assert property ($fell(output_strobe_n) && pdat |-> flash_addr == paddr)
    else $error("status read at wrong address");
  AST_WRITE_GATE: assert property (!write_strobe_n |->
    !chip_select_n && output_strobe_n && !dq_oe_n) else $error("bad write pulse");
  AST_READ_SAFE: assert property (!output_strobe_n |-> !chip_select_n && dq_oe_n)
    else $error("bad read cycle");
  AST_WR_HOLD: assert property (!write_strobe_n && $past(!write_strobe_n) |->
    $stable(flash_addr) && $stable(dq_out)) else $error("write moved");
  AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  AST_R_ANSWER: assert property (s_ar_take |=> s_axi_rvalid) else $error("late rvalid");
endmodule // fpsr_host_props
bind fpsr_host fpsr_host_props #(.AW(AW)) props_u (.sys_clk, .rstn, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_arvalid,
  .s_axi_arready, .flash_addr, .chip_select_n, .write_strobe_n, .output_strobe_n,
  .dq_out, .dq_oe_n);

// *** tb/fpsr_flash_model.sv ***
`timescale 1ns/1ps
module fpsr_flash_model #(
  parameter PROG_NS = 3000,
  parameter TOUT_NS = 4000,
  parameter PROT_NS = 2000,
  parameter [19:0] PROT_BASE = 20'hF0000
) (
  input wire [19:0] flash_addr,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire [7:0] dq_out,
  input wire stuck,
  output reg [7:0] dq_in,
  output wire ready_busy_n
);
  reg [19:0] la = 0, pa = 0, ma = 0;
  reg [7:0] pd = 8'h00, mem = 8'hFF;
  reg [1:0] step = 2'h0;
  reg busy = 1'b0, tog = 1'b0, tout = 1'b0, prot = 1'b0;
  integer gen = 0;
  wire wr = ~(write_strobe_n | chip_select_n);
  wire rd = ~(output_strobe_n | chip_select_n);
  initial dq_in = 8'h00;
  // open drain, pulled up when not busy
  // A protected target programs nothing, so the pin stays released
  assign ready_busy_n = (busy && !prot) ? 1'b0 : 1'b1;
  // address on the later falling edge
  always @(posedge wr) la = flash_addr;
  // command decode on the earlier rising edge
  always @(negedge wr) begin
    if (step == 2'h3 && !busy) begin
      pd = dq_out;
      pa = la;
      busy = 1'b1;
      prot = (la >= PROT_BASE);
      step = 2'h0;
      gen = gen + 1;
      fork run(gen); join_none
    end else if (dq_out == 8'hF0) begin
      step = 2'h0;
      busy = 1'b0;
      tout = 1'b0;
      prot = 1'b0;
    end else if (busy) step = 2'h0;
    else step = (step == 2'h0 && la == 20'h00555 && dq_out == 8'hAA) ? 2'h1 :
      (step == 2'h1 && la == 20'h002AA && dq_out == 8'h55) ? 2'h2 :
      (step == 2'h2 && la == 20'h00555 && dq_out == 8'hA0) ? 2'h3 : 2'h0;
  end
  // self-timed program; a stuck cell only ever times out
  // protected target toggles a while, then array read, cell untouched
  task automatic run(input integer g);
    if (prot) begin
      #(PROT_NS);
      if (g == gen) begin
        busy = 1'b0;
        prot = 1'b0;
      end
    end else if (stuck) begin
      #(TOUT_NS);
      if (g == gen && busy) tout = 1'b1;
    end else begin
      #(PROG_NS);
      if (g == gen) begin
        busy = 1'b0;
        mem = pd;
        ma = pa;
      end
    end
  endtask
  // status while busy, array data otherwise
  always @(posedge rd) begin
    if (busy) begin
      dq_in = {~pd[7], tog, tout, 5'h00};
      tog = ~tog;
    end else dq_in = (flash_addr == ma) ? mem : 8'hFF;
  end
  // Released bus shows the inverse so stale data cannot pass
  always @(negedge rd) dq_in = ~dq_in;
endmodule // fpsr_flash_model

// *** tb/flash_program_status_report_bench.sv ***
`timescale 1ns/1ps
`include "fpsr_defs.vh"
module flash_program_status_report_bench;
  // Bus and flash nets
  reg sys_clk = 1'b0, rstn = 1'b0, stuck = 1'b0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, rd_val, a, d, st_want;
  wire awready, wready, bvalid, arready, rvalid, cs_n, we_n, oe_n, dq_oe_n, rb_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [19:0] fa;
  wire [7:0] dqo, dqi;
  reg [65:0] exp_q[$];
  reg [65:0] e;
  integer err_total = 0, check_count = 0, i;

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  fpsr_host dut_u (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_addr(fa),
    .chip_select_n(cs_n), .write_strobe_n(we_n), .output_strobe_n(oe_n), .dq_out(dqo),
    .dq_oe_n(dq_oe_n), .dq_in(dqi), .ready_busy_n(rb_n));

  fpsr_flash_model flash_u (.flash_addr(fa), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_strobe_n(oe_n), .dq_out(dqo), .stuck(stuck), .dq_in(dqi), .ready_busy_n(rb_n));

  task check(input [33:0] seen, input [33:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // One AXI transfer; every channel is judged at the rising edge and released after it
  task bus(input w, input [7:0] ad, input [31:0] dt, input [1:0] er, input [31:0] m,
      input [31:0] ed);
    reg pa, pw, pr;
    integer n, hold;
    begin
      exp_q.push_back({er, m, ed});
      // Response ready comes up to three cycles late, so a waiting response is seen
      hold = $urandom & 3;
      @(posedge sys_clk);
      if (w) begin
        awaddr <= ad;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (hold == 0);
      end else begin
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= (hold == 0);
      end
      pa = 1'b1;
      pw = w;
      pr = 1'b1;
      n = 0;
      while (pa || pw || pr) begin
        @(posedge sys_clk);
        if (pa && ((awvalid && awready) || (arvalid && arready))) begin
          awvalid <= 1'b0;
          arvalid <= 1'b0;
          pa = 1'b0;
        end
        if (pw && wvalid && wready) begin
          wvalid <= 1'b0;
          pw = 1'b0;
        end
        if (pr && ((bvalid && bready) || (rvalid && rready))) begin
          rd_val = rdata;
          bready <= 1'b0;
          rready <= 1'b0;
          pr = 1'b0;
        end else if (pr && hold > 0) begin
          hold = hold - 1;
          if (hold == 0) begin
            if (w) bready <= 1'b1;
            else rready <= 1'b1;
          end
        end
        n = n + 1;
        if (n > 300) begin
          err_total = err_total + 1;
          stop_test;
        end
      end
    end
  endtask

  // Read status until idle, bounded
  task poll;
    integer n;
    begin
      n = 0;
      rd_val = 32'h1;
      while (rd_val[`FPSR_ST_BUSY] !== 1'b0) begin
        bus(1'b0, `FPSR_REG_STAT, 0, 2'h0, 32'h0, 32'h0);
        n = n + 1;
        if (n > 200) begin
          err_total = err_total + 1;
          stop_test;
        end
      end
    end
  endtask

  // Compare each response with the oldest note
  always @(posedge sys_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = exp_q.pop_front();
      check({bvalid ? bresp : rresp, rdata & e[63:32]}, {e[65:64], e[31:0]});
    end
  end

  initial begin
    void'($urandom(60));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, `FPSR_REG_STAT, 0, 2'h0, 32'hF, 32'h8);
    bus(1'b0, 8'h20, 0, 2'h2, 32'h0, 32'h0);
    bus(1'b1, 8'h24, 0, 2'h2, 32'h0, 32'h0);
    // Odd passes leave the cell stuck so the timeout path runs; pass four hits protection
    for (i = 0; i < 5; i = i + 1) begin
      a = (i == 4) ? (32'hF0000 | ($urandom & 32'hFFFF)) : ($urandom & 32'h7FFFF);
      d = $urandom & 32'hFF;
      stuck <= i[0];
      bus(1'b1, `FPSR_REG_ADDR, a, 2'h0, 32'h0, 32'h0);
      bus(1'b1, `FPSR_REG_DATA, d, 2'h0, 32'h0, 32'h0);
      bus(1'b1, `FPSR_REG_CTRL, 32'h1, 2'h0, 32'h0, 32'h0);
      bus(1'b0, `FPSR_REG_STAT, 0, 2'h0, 32'h9, 32'h9);
      bus(1'b1, `FPSR_REG_CTRL, 32'h5, 2'h0, 32'h0, 32'h0);
      poll;
      st_want = i[0] ? 32'h6 : (i == 4) ? {29'h0, ~d[7], 2'h2} : 32'h2;
      bus(1'b0, `FPSR_REG_STAT, 0, 2'h0, 32'h7, st_want);
      bus(1'b1, `FPSR_REG_CTRL, 32'h3, 2'h0, 32'h0, 32'h0);
      poll;
      bus(1'b0, `FPSR_REG_RDAT, 0, 2'h0, 32'hFF, (i[0] || i == 4) ? 32'hFF : d);
    end
    // Second reset clears the sticky status
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, `FPSR_REG_STAT, 0, 2'h0, 32'hF, 32'h8);
    stop_test;
  end
endmodule // flash_program_status_report_bench
